// ---- common/sector_lock_pkg.sv ----
package sector_lock_pkg;

	// Clock rate of ref_clk_i
	localparam int unsigned CLK_MHZ = 50;

	// Command opcodes seen on the serial bus
	localparam logic [7:0] OPC_WR_EN    = 8'h06;
	localparam logic [7:0] OPC_RD_SR    = 8'h05;
	localparam logic [7:0] OPC_WR_SR    = 8'h01;
	localparam logic [7:0] OPC_RD_FSR   = 8'h70;
	localparam logic [7:0] OPC_CLR_FSR  = 8'h50;
	localparam logic [7:0] OPC_RD_PMR   = 8'h2b;
	localparam logic [7:0] OPC_WR_PMR   = 8'h68;
	localparam logic [7:0] OPC_RD_NVL   = 8'he2;
	localparam logic [7:0] OPC_WR_NVL   = 8'he3;
	localparam logic [7:0] OPC_ER_NVL   = 8'he4;
	localparam logic [7:0] OPC_RD_VL    = 8'he8;
	localparam logic [7:0] OPC_WR_VL    = 8'he5;
	localparam logic [7:0] OPC_SOFT_RST = 8'h99;

	// Temporary lock register fields
	localparam int unsigned VL_WP_BIT = 0;
	localparam int unsigned VL_LD_BIT = 1;

	// Protection management register fields
	localparam int unsigned PMR_NV_ERASE_LOCK = 0;
	localparam int unsigned PMR_NV_LOCKDOWN   = 1;
	localparam int unsigned PMR_LOCKDOWN      = 2;
	localparam int unsigned PMR_SR_LOCK       = 4;
	localparam logic [7:0]  PMR_RESERVED_MASK = 8'he8;
	localparam logic [7:0]  PMR_RESET         = 8'hff;

	// Persistent lock read values
	localparam logic [7:0] NVL_READ_LOCKED = 8'h00;
	localparam logic [7:0] NVL_READ_OPEN   = 8'hff;

	// Flag status and main status fields
	localparam int unsigned FSR_READY    = 7;
	localparam int unsigned FSR_PROG_ERR = 4;
	localparam int unsigned FSR_PROT_ERR = 1;
	localparam int unsigned SR_WEL       = 1;
	localparam int unsigned SR_WIP       = 0;
	localparam logic [5:0]  SR_RESET     = 6'h00;

	// Self-timed operation lengths
	localparam int unsigned T_BYTE_PROG_US  = 20;
	localparam int unsigned T_SECT_ERASE_US = 1000;
	localparam int unsigned T_PMR_PROG_US   = 40;
	localparam int unsigned BYTE_PROG_CYC   = T_BYTE_PROG_US * CLK_MHZ;
	localparam int unsigned PMR_PROG_CYC    = T_PMR_PROG_US * CLK_MHZ;
	localparam int unsigned TMR_W           = 20;

	// Operation held by the busy timer
	typedef enum logic [1:0] {OP_NONE, OP_NVL_PROG, OP_NVL_ERASE, OP_PMR_PROG} busy_op_t;

endpackage : sector_lock_pkg

// ---- verilog/busy_timer.sv ----
`timescale 1ns/100ps
module busy_timer #(
	parameter int unsigned CNT_W = 20
) (
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	// Start with cycle count
	input  wire logic             start_i,
	input  wire logic [CNT_W-1:0] count_i,
	// Status
	output logic                  busy_o,
	output logic                  done_o
);

	logic [CNT_W-1:0] remain;

	// Down counter; a reset abandons the running operation
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			remain <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				remain <= count_i - 1'b1;
				busy_o <= 1'b1;
			end else if (busy_o) begin
				if (remain == '0) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					remain <= remain - 1'b1;
				end
			end
		end
	end

endmodule : busy_timer

// ---- verilog/sector_lock_protection_logic.sv ----
`timescale 1ns/100ps
// How it works
// - Persistent bit zero blocks sector modify
// - Temporary bit one blocks sector modify
// - Persistent write programs bit zero, byte time
// - Persistent erase sets all bits, erase time
// - Program per sector, erase only whole array
// - Reset clears every temporary lock bit
// - Persistent read gives 00h locked, FFh open
// - Separate reads for persistent and temporary locks
// - Temporary write only while lock-down is zero
// - Lock-down freezes both fields until reset
// - Bit0 write-protect blocks modify; bits7:2 zero
// - Management lockdown ignores writes, flags errors
// - Status lock permanently rejects status writes
// - Lockdown bit blocks persistent program and erase
// - Erase lock bit forbids persistent array erase
// - Management fields only go one to zero
// - Management read 2Bh, write 68h, no erase
// - Reserved zero aborts, clears latch, flags errors
module sector_lock_protection_logic
	import sector_lock_pkg::*;
#(
	parameter int unsigned N_SECTORS      = 256,
	parameter int unsigned SECT_ERASE_CYC = T_SECT_ERASE_US * CLK_MHZ
) (
	// Clock and resets
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         por_n_i,
	// Serial bus
	input  wire logic                         sclk_i,
	input  wire logic                         cs_n_i,
	input  wire logic                         mosi_i,
	output logic                              miso_o,
	output logic                              miso_oe_o,
	// Array modify check
	input  wire logic                         mod_req_i,
	input  wire logic [$clog2(N_SECTORS)-1:0] mod_sector_i,
	output logic                              mod_grant_o,
	output logic                              mod_deny_o
);

	localparam int unsigned SEC_W = $clog2(N_SECTORS);

	// Lock state
	logic [N_SECTORS-1:0] nv_open;
	logic [N_SECTORS-1:0] vl_wp;
	logic [N_SECTORS-1:0] vl_ld;
	logic [7:0]           protection_management;
	logic [5:0]           sr_bits;
	logic                 wel;
	logic                 err_prog;
	logic                 err_prot;

	// Serial front end
	logic       sclk_s1, sclk_s2, sclk_s3;
	logic       cs_s1, cs_s2, cs_s3;
	logic       mosi_s1, mosi_s2;
	logic [6:0] in_sh;
	logic [2:0] bit_cnt;
	logic [1:0] byte_cnt;
	logic [7:0] opc;
	logic [7:0] arg1;
	logic [7:0] arg2;
	logic [7:0] out_sh;

	// Busy operation
	busy_op_t             op_kind;
	logic [SEC_W-1:0]     op_sec;
	logic [7:0]           op_data;
	logic                 tmr_start;
	logic [TMR_W-1:0]     tmr_count;
	logic                 busy;
	logic                 tmr_done;

	// Sector open for modify when neither lock holds it
	function automatic logic sector_open(input logic [SEC_W-1:0] idx, input logic [N_SECTORS-1:0] nv,
			input logic [N_SECTORS-1:0] wp);
		sector_open = nv[idx] && !wp[idx];
	endfunction : sector_open

	// Two flops before any use; stage 3 is only for edge finding
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{cs_s1, cs_s2, cs_s3}       <= 3'h7;
			{mosi_s1, mosi_s2}          <= 2'h0;
		end else begin
			sclk_s1 <= sclk_i;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1   <= cs_n_i;
			cs_s2   <= cs_s1;
			cs_s3   <= cs_s2;
			mosi_s1 <= mosi_i;
			mosi_s2 <= mosi_s1;
		end
	end

	logic       sclk_rise, sclk_fall, cs_act, cs_rise;
	logic [7:0] in_byte;
	assign sclk_rise = sclk_s2 && !sclk_s3;
	assign sclk_fall = !sclk_s2 && sclk_s3;
	assign cs_act    = !cs_s2;
	assign cs_rise   = cs_s2 && !cs_s3;
	assign in_byte   = {in_sh, mosi_s2};

	// Input shift on rising serial edge, bytes counted per frame
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !cs_act) begin
			in_sh    <= 7'h00;
			bit_cnt  <= 3'h0;
			byte_cnt <= 2'h0;
		end else if (sclk_rise) begin
			in_sh   <= in_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7 && byte_cnt != 2'h3) begin
				byte_cnt <= byte_cnt + 2'h1;
			end
		end
	end

	// Command and argument bytes
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			opc  <= 8'h00;
			arg1 <= 8'h00;
			arg2 <= 8'h00;
		end else if (cs_act && sclk_rise && bit_cnt == 3'h7) begin
			unique case (byte_cnt)
				2'h0: opc <= in_byte;
				2'h1: arg1 <= in_byte;
				2'h2: arg2 <= in_byte;
				2'h3: ;
			endcase
		end
	end

	// Read answers
	logic             sec_read;
	logic             rd_cmd;
	logic [SEC_W-1:0] arg_sec;
	logic [7:0]       resp;
	assign arg_sec  = arg1[SEC_W-1:0];
	assign sec_read = (opc == OPC_RD_NVL) || (opc == OPC_RD_VL);
	assign rd_cmd   = sec_read || opc == OPC_RD_PMR || opc == OPC_RD_FSR || opc == OPC_RD_SR;

	always_comb begin
		resp = 8'h00;
		unique case (opc)
			OPC_RD_NVL: resp = nv_open[arg_sec] ? NVL_READ_OPEN : NVL_READ_LOCKED;
			OPC_RD_VL: begin
				resp[VL_WP_BIT] = vl_wp[arg_sec];
				resp[VL_LD_BIT] = vl_ld[arg_sec];
			end
			OPC_RD_PMR: resp = protection_management;
			OPC_RD_FSR: begin
				resp[FSR_READY]    = !busy;
				resp[FSR_PROG_ERR] = err_prog;
				resp[FSR_PROT_ERR] = err_prot;
			end
			OPC_RD_SR: resp = {sr_bits, wel, busy};
			default: resp = 8'h00;
		endcase
	end

	// Output shift on falling serial edge; same byte repeats
	logic rd_phase;
	assign rd_phase = cs_act && rd_cmd && (byte_cnt >= (sec_read ? 2'h2 : 2'h1));

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			out_sh    <= 8'h00;
			miso_o    <= 1'b0;
			miso_oe_o <= 1'b0;
		end else begin
			miso_oe_o <= rd_phase;
			if (rd_phase && sclk_fall) begin
				if (bit_cnt == 3'h0) begin
					miso_o <= resp[7];
					out_sh <= {resp[6:0], 1'b0};
				end else begin
					miso_o <= out_sh[7];
					out_sh <= {out_sh[6:0], 1'b0};
				end
			end
		end
	end

	// Commands act when the frame ends on a byte boundary while the timer is not busy
	logic frame_done;
	logic ex_wren, ex_wr_sr, ex_wr_nvl, ex_er_nvl, ex_wr_vl, ex_wr_pmr, ex_clr_fsr, ex_soft_rst;
	assign frame_done  = cs_rise && bit_cnt == 3'h0 && !busy;
	assign ex_wren     = frame_done && byte_cnt == 2'h1 && opc == OPC_WR_EN;
	assign ex_clr_fsr  = frame_done && byte_cnt == 2'h1 && opc == OPC_CLR_FSR;
	assign ex_soft_rst = frame_done && byte_cnt == 2'h1 && opc == OPC_SOFT_RST;
	assign ex_er_nvl   = frame_done && byte_cnt == 2'h1 && opc == OPC_ER_NVL && wel;
	assign ex_wr_nvl   = frame_done && byte_cnt == 2'h2 && opc == OPC_WR_NVL && wel;
	assign ex_wr_sr    = frame_done && byte_cnt == 2'h2 && opc == OPC_WR_SR && wel;
	assign ex_wr_pmr   = frame_done && byte_cnt == 2'h2 && opc == OPC_WR_PMR && wel;
	assign ex_wr_vl    = frame_done && byte_cnt == 2'h3 && opc == OPC_WR_VL && wel;

	// Refusal conditions
	logic pmr_frozen, pmr_bad, nvl_prog_blk, nvl_erase_blk, sr_blk, vl_blk;
	assign pmr_frozen    = !protection_management[PMR_LOCKDOWN];
	assign pmr_bad       = (arg1 & PMR_RESERVED_MASK) != PMR_RESERVED_MASK;
	assign nvl_prog_blk  = !protection_management[PMR_NV_LOCKDOWN];
	assign nvl_erase_blk = !protection_management[PMR_NV_LOCKDOWN] || !protection_management[PMR_NV_ERASE_LOCK];
	assign sr_blk        = !protection_management[PMR_SR_LOCK];
	assign vl_blk        = vl_ld[arg_sec];

	// Write enable latch; a frozen management write leaves it set
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !por_n_i || ex_soft_rst) begin
			wel <= 1'b0;
		end else if (ex_wren) begin
			wel <= 1'b1;
		end else if (ex_wr_sr || ex_wr_nvl || ex_er_nvl || ex_wr_vl || (ex_wr_pmr && !pmr_frozen)) begin
			wel <= 1'b0;
		end
	end

	// Error flags; a new error wins over a clear in the same cycle
	logic set_prog, set_prot;
	assign set_prog = ex_wr_pmr && (pmr_frozen || pmr_bad);
	assign set_prot = set_prog || (ex_wr_nvl && nvl_prog_blk) || (ex_er_nvl && nvl_erase_blk)
		|| (ex_wr_sr && sr_blk) || (ex_wr_vl && vl_blk);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !por_n_i || ex_soft_rst) begin
			err_prog <= 1'b0;
			err_prot <= 1'b0;
		end else begin
			err_prog <= set_prog || (err_prog && !ex_clr_fsr);
			err_prot <= set_prot || (err_prot && !ex_clr_fsr);
		end
	end

	// Main status bits, frozen once the status lock is programmed
	always_ff @(posedge ref_clk_i) begin
		if (!por_n_i) begin
			sr_bits <= SR_RESET;
		end else if (ex_wr_sr && !sr_blk) begin
			sr_bits <= arg1[7:2];
		end
	end

	// Temporary locks; lock-down stops further writes until reset
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !por_n_i || ex_soft_rst) begin
			vl_wp <= '0;
			vl_ld <= '0;
		end else if (ex_wr_vl && !vl_blk) begin
			vl_wp[arg_sec] <= arg2[VL_WP_BIT];
			vl_ld[arg_sec] <= arg2[VL_LD_BIT];
		end
	end

	// Start of self-timed operations
	always_comb begin
		tmr_start = 1'b0;
		tmr_count = '0;
		if (ex_wr_nvl && !nvl_prog_blk) begin
			tmr_start = 1'b1;
			tmr_count = TMR_W'(BYTE_PROG_CYC);
		end else if (ex_er_nvl && !nvl_erase_blk) begin
			tmr_start = 1'b1;
			tmr_count = TMR_W'(SECT_ERASE_CYC);
		end else if (ex_wr_pmr && !pmr_frozen && !pmr_bad) begin
			tmr_start = 1'b1;
			tmr_count = TMR_W'(PMR_PROG_CYC);
		end
	end

	// Operation record for completion
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !por_n_i) begin
			op_kind <= OP_NONE;
			op_sec  <= '0;
			op_data <= 8'hff;
		end else if (tmr_start) begin
			op_sec  <= arg_sec;
			op_data <= arg1;
			if (opc == OPC_WR_NVL) begin
				op_kind <= OP_NVL_PROG;
			end else if (opc == OPC_ER_NVL) begin
				op_kind <= OP_NVL_ERASE;
			end else begin
				op_kind <= OP_PMR_PROG;
			end
		end else if (tmr_done) begin
			op_kind <= OP_NONE;
		end
	end

	busy_timer #(
		.CNT_W (TMR_W)
	) u_busy_timer (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i && por_n_i),
		.start_i   (tmr_start),
		.count_i   (tmr_count),
		.busy_o    (busy),
		.done_o    (tmr_done)
	);

	// Persistent locks survive resets; only power-on sets the shipped state
	always_ff @(posedge ref_clk_i) begin
		if (!por_n_i) begin
			nv_open <= '1;
		end else if (tmr_done && op_kind == OP_NVL_PROG) begin
			nv_open[op_sec] <= 1'b0;
		end else if (tmr_done && op_kind == OP_NVL_ERASE) begin
			nv_open <= '1;
		end
	end

	// Management fields can only be cleared, never set back
	always_ff @(posedge ref_clk_i) begin
		if (!por_n_i) begin
			protection_management <= PMR_RESET;
		end else if (tmr_done && op_kind == OP_PMR_PROG) begin
			protection_management <= protection_management & op_data;
		end
	end

	// Modify check for the array controller
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mod_grant_o <= 1'b0;
			mod_deny_o  <= 1'b0;
		end else begin
			mod_grant_o <= mod_req_i && sector_open(mod_sector_i, nv_open, vl_wp);
			mod_deny_o  <= mod_req_i && !sector_open(mod_sector_i, nv_open, vl_wp);
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i || !por_n_i);

	sequence seq_req_nv_locked;
		mod_req_i && !nv_open[mod_sector_i];
	endsequence

	sequence seq_req_vl_locked;
		mod_req_i && vl_wp[mod_sector_i];
	endsequence

	sequence seq_prog_done;
		tmr_done && op_kind == OP_NVL_PROG;
	endsequence

	AST_NV_DENY: assert property (seq_req_nv_locked |=> mod_deny_o && !mod_grant_o)
		else $error("persistent lock did not deny modify");
	AST_VL_DENY: assert property (seq_req_vl_locked |=> mod_deny_o && !mod_grant_o)
		else $error("temporary lock did not deny modify");
	AST_GRANT: assert property (mod_req_i && nv_open[mod_sector_i] && !vl_wp[mod_sector_i] |=> mod_grant_o)
		else $error("open sector was not granted");
	AST_RESET_CLEAR: assert property (@(posedge ref_clk_i) disable iff (1'b0) !rst_n_i |=> vl_wp == '0 && vl_ld == '0)
		else $error("temporary locks survived reset");
	AST_PROG_TIME: assert property (ex_wr_nvl && !nvl_prog_blk |=> busy [*8] ##0 !nv_open[op_sec] == 1'b0)
		else $error("persistent program did not stay busy");
	AST_PROG_DONE: assert property (seq_prog_done |=> !nv_open[$past(op_sec)])
		else $error("persistent bit not programmed");
	AST_ERASE_DONE: assert property (tmr_done && op_kind == OP_NVL_ERASE |=> &nv_open)
		else $error("persistent erase did not set all bits");
	AST_LD_FREEZE: assert property (ex_wr_vl && vl_blk |=> $stable(vl_wp) && $stable(vl_ld) && err_prot)
		else $error("locked-down sector was written");
	AST_PMR_FROZEN: assert property (ex_wr_pmr && pmr_frozen |=> !busy && wel && err_prog && err_prot)
		else $error("frozen management write not refused");
	AST_PMR_ONE_WAY: assert property ((protection_management & ~$past(protection_management)) == 8'h00)
		else $error("management bit went back to one");
	AST_SR_LOCKED: assert property (ex_wr_sr && sr_blk |=> $stable(sr_bits))
		else $error("locked status register was written");
	AST_NV_LOCKDOWN: assert property ((ex_wr_nvl || ex_er_nvl) && nvl_prog_blk |=> !busy ##1 $stable(nv_open))
		else $error("persistent locks changed under lockdown");
	AST_NO_ERASE: assert property (ex_er_nvl && !protection_management[PMR_NV_ERASE_LOCK] |=> !busy && err_prot)
		else $error("erase ran while erase lock set");
	AST_PMR_ABORT: assert property (ex_wr_pmr && !pmr_frozen && pmr_bad |=> !busy && !wel && err_prog)
		else $error("reserved-zero management write not aborted");

endmodule : sector_lock_protection_logic

// ---- testbench/spi_host_model.sv ----
`timescale 1ns/100ps
module spi_host_model
	import sector_lock_pkg::*;
(
	// Clock
	input  wire logic ref_clk_i,
	// Serial bus
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i,
	input  wire logic miso_oe_i
);
	// Idle bus: clock parked low, select high
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// Released data line toggles so a stale bit never looks valid
	always @(posedge ref_clk_i) begin
		if (cs_n_o) begin
			mosi_o <= ~mosi_o;
		end
	end

	// Mode 0 frame of 160 ns bits: n_tx bytes out (top byte first), then n_rd bytes in
	task automatic xfer(input int n_tx, input logic [31:0] tx, input int n_rd, output logic [7:0] rd);
		logic [31:0] sh;
		sh = tx << (8 * (4 - n_tx));
		rd = 8'h00;
		@(posedge ref_clk_i) cs_n_o <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		for (int i = 0; i < 8 * (n_tx + n_rd); i++) begin
			@(posedge ref_clk_i) begin
				sclk_o <= 1'b0;
				mosi_o <= sh[31];
			end
			sh = sh << 1;
			repeat (3) @(posedge ref_clk_i);
			@(posedge ref_clk_i) sclk_o <= 1'b1;
			repeat (2) @(posedge ref_clk_i);
			// Mid high phase: output is settled and not yet shifted
			// Undriven line shows the inverse, so a missing enable spoils the byte
			#1 if (i >= 8 * n_tx) rd = {rd[6:0], miso_oe_i ? miso_i : ~miso_i};
			@(posedge ref_clk_i);
		end
		@(posedge ref_clk_i) begin
			sclk_o <= 1'b0;
			cs_n_o <= 1'b1;
		end
		repeat (8) @(posedge ref_clk_i);
	endtask : xfer

	// Every write goes behind a latch set in the frame before
	task automatic wr_xfer(input int n_tx, input logic [31:0] tx);
		logic [7:0] nul;
		xfer(1, {24'h0, OPC_WR_EN}, 0, nul);
		xfer(n_tx, tx, 0, nul);
	endtask : wr_xfer
endmodule : spi_host_model

// ---- testbench/sector_lock_protection_logic_tb.sv ----
`timescale 1ns/100ps
module sector_lock_protection_logic_tb
	import sector_lock_pkg::*;
;
	localparam int unsigned NS        = 8;
	localparam int unsigned ERASE_CYC = 200;

	// Bench signals and expected state
	logic          ref_clk_i, rst_n_i, por_n_i, sclk, cs_n, mosi, miso, miso_oe;
	logic          mod_req, mod_grant, mod_deny;
	logic [2:0]    mod_sector;
	logic [NS-1:0] exp_nv, exp_wp, exp_ld;
	logic [7:0]    exp_pmr, dmy;
	int            error_cnt, comparisons, s, t, n;

	sector_lock_protection_logic #(.N_SECTORS(NS), .SECT_ERASE_CYC(ERASE_CYC)) dut_u (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .mod_req_i(mod_req),
		.mod_sector_i(mod_sector), .mod_grant_o(mod_grant), .mod_deny_o(mod_deny));

	spi_host_model host_u (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_i(miso_oe));

	// Expected modify verdict of one sector
	function automatic logic locked(input int sct);
		return !exp_nv[sct] || exp_wp[sct];
	endfunction : locked

	// 50 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	task automatic final_report();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rd_reg(input int nb, input logic [15:0] hdr, input logic [7:0] exp);
		logic [7:0] v;
		host_u.xfer(nb, {16'h0, hdr}, 1, v);
		chk(v, exp);
	endtask : rd_reg

	// Modify request answered one cycle later
	task automatic chk_mod(input int sct);
		logic lk;
		lk = locked(sct);
		@(posedge ref_clk_i) begin
			mod_req    <= 1'b1;
			mod_sector <= 3'(sct);
		end
		@(posedge ref_clk_i) mod_req <= 1'b0;
		// Bus is idle here, so the data enable must be low too
		#1 chk({5'h0, miso_oe, mod_grant, mod_deny}, {5'h0, 1'b0, ~lk, lk});
	endtask : chk_mod

	// Bounded poll of the ready flag; polls counts busy answers
	task automatic wait_ready(output int polls);
		logic [7:0] v;
		for (polls = 0; polls < 100; polls++) begin
			host_u.xfer(1, {24'h0, OPC_RD_FSR}, 1, v);
			if (v[FSR_READY] === 1'b1) break;
		end
		chk(v & 8'h80, 8'h80);
	endtask : wait_ready

	// Write, wait, check error flags against emask, then clear them
	task automatic op(input int nb, input logic [31:0] tx, input logic [7:0] emask, output int polls);
		logic [7:0] v;
		host_u.wr_xfer(nb, tx);
		wait_ready(polls);
		host_u.xfer(1, {24'h0, OPC_RD_FSR}, 1, v);
		chk(v & 8'h12, emask);
		host_u.xfer(1, {24'h0, OPC_CLR_FSR}, 0, v);
	endtask : op

	task automatic sweep();
		for (int i = 0; i < NS; i++) begin
			rd_reg(2, {OPC_RD_NVL, 8'(i)}, exp_nv[i] ? NVL_READ_OPEN : NVL_READ_LOCKED);
			rd_reg(2, {OPC_RD_VL, 8'(i)}, {6'h0, exp_ld[i], exp_wp[i]});
			chk_mod(i);
		end
		chk_mod($urandom_range(NS - 1));
	endtask : sweep

	// Management write; expectation from lock-down and reserved fields
	task automatic wr_pmr(input logic [7:0] d);
		logic       lk, ok;
		logic [7:0] v;
		int         p;
		lk = ~exp_pmr[PMR_LOCKDOWN];
		ok = !lk && ((d & PMR_RESERVED_MASK) == PMR_RESERVED_MASK);
		op(2, {16'h0, OPC_WR_PMR, d}, ok ? 8'h00 : 8'h12, p);
		if (ok) exp_pmr = exp_pmr & d;
		rd_reg(1, {8'h0, OPC_RD_PMR}, exp_pmr);
		host_u.xfer(1, {24'h0, OPC_RD_SR}, 1, v);
		chk({7'h0, v[SR_WEL]}, {7'h0, lk});
	endtask : wr_pmr

	// Hang guard, well above the expected run length
	initial begin
		repeat (95000) @(posedge ref_clk_i);
		error_cnt++;
		final_report();
	end

	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		por_n_i = 1'b0;
		mod_req = 1'b0;
		mod_sector = 3'h0;
		error_cnt = 0;
		comparisons = 0;
		exp_nv = '1;
		exp_wp = '0;
		exp_ld = '0;
		exp_pmr = PMR_RESET;
		void'($urandom(32'hfe05));
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		por_n_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		s = $urandom_range(NS - 1);
		t = (s + 1 + $urandom_range(NS - 2)) % NS;
		sweep();
		rd_reg(1, {8'h0, OPC_RD_PMR}, PMR_RESET);
		// Persistent lock on one sector, busy for a byte time
		op(2, {16'h0, OPC_WR_NVL, 8'(s)}, 8'h00, n);
		chk(8'(n > 0), 8'h01);
		exp_nv[s] = 1'b0;
		sweep();
		// Temporary protect, then lock-down freezes both fields
		op(3, {8'h0, OPC_WR_VL, 8'(t), 8'h01}, 8'h00, n);
		op(3, {8'h0, OPC_WR_VL, 8'(t), 8'h03}, 8'h00, n);
		op(3, {8'h0, OPC_WR_VL, 8'(t), 8'h00}, 8'h02, n);
		exp_wp[t] = 1'b1;
		exp_ld[t] = 1'b1;
		sweep();
		// Soft reset clears temporary state only
		host_u.xfer(1, {24'h0, OPC_SOFT_RST}, 0, dmy);
		exp_wp = '0;
		exp_ld = '0;
		sweep();
		// Hardware reset in mid-run
		op(3, {8'h0, OPC_WR_VL, 8'(t), 8'h01}, 8'h00, n);
		@(posedge ref_clk_i) rst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		sweep();
		// Whole-array erase
		op(1, {24'h0, OPC_ER_NVL}, 8'h00, n);
		exp_nv = '1;
		sweep();
		op(2, {16'h0, OPC_WR_NVL, 8'(s)}, 8'h00, n);
		exp_nv[s] = 1'b0;
		op(2, {16'h0, OPC_WR_SR, 8'h5c}, 8'h00, n);
		rd_reg(1, {8'h0, OPC_RD_SR}, 8'h5c);
		// Management register: abort, one-way fields, freezes
		wr_pmr(8'hf7);
		wr_pmr(8'hfe);
		op(1, {24'h0, OPC_ER_NVL}, 8'h02, n);
		wr_pmr(8'hfd);
		op(2, {16'h0, OPC_WR_NVL, 8'(t)}, 8'h02, n);
		sweep();
		wr_pmr(8'hff);
		wr_pmr(8'hef);
		op(2, {16'h0, OPC_WR_SR, 8'h00}, 8'h02, n);
		rd_reg(1, {8'h0, OPC_RD_SR}, 8'h5c);
		wr_pmr(8'hfb);
		wr_pmr(8'h00);
		final_report();
	end
endmodule : sector_lock_protection_logic_tb
